// >>> adc_seq_consts.svh
/*
 Constants of the converter result-buffer sequencer: widths, counts, reset values.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
`define RESULT_WIDTH        12
`define BUFFER_COUNT        16
`define SAMPLES_PER_INTERRUPT_COUNT_WIDTH          5
`define DMA_ADDR_WIDTH      16
`define DMA_ADVANCE_EVERY   32
`define RESULT_RESET        12'h000
`define DMA_ADDR_RESET      16'h0000
`endif

// >>> adc_seq_pkg.sv
/*
 Types of the converter result-buffer sequencer.
 Assumes adc_seq_consts.svh is on the include path.
*/
`include "adc_seq_consts.svh"
package adc_seq_pkg;
    typedef logic [`RESULT_WIDTH-1:0]   result_type;
    typedef logic [`SAMPLES_PER_INTERRUPT_COUNT_WIDTH-1:0]     samples_per_interrupt_count_type;
    typedef logic [`DMA_ADDR_WIDTH-1:0] dma_addr_type;
    typedef logic [3:0]                 buf_index_type;
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_BUSY
    } conv_state_type;
endpackage : adc_seq_pkg

// >>> adc_result_buffer_sequencer.sv
/*
 Result buffers and sequencing control for an analog-to-digital converter.
 Assumes the converter core pulses convStart and convDone on sys_clk, and that
 the reader drains the single buffer in DMA mode before the next result.
*/
`timescale 1ns/10ps
`include "adc_seq_consts.svh"

// Behaviour
// - Interrupt flag at sample count; request gated by enable
// - Scan list restarts at sample count
// - Buffer pointer returns to start at count, outside fill mode
// - DMA mode writes only first result buffer
// - DMA address advances every 32nd conversion
// - Sixteen buffers filled in order without DMA
// - Buffer chosen by sequence, not input
// - Done flag cleared at start, set at end
// - Fill mode alternates halves per interrupt
module adc_result_buffer_sequencer #(
    parameter int BUFFERS = `BUFFER_COUNT,
    parameter int DMA_EVERY = `DMA_ADVANCE_EVERY
) (
    input  wire logic                      sys_clk,
    input  wire logic                      arst_n,
    input  wire logic                      clkEn,
    input  wire logic                      convStart,
    input  wire logic                      convDone,
    input  wire adc_seq_pkg::result_type   convResult,
    input  wire adc_seq_pkg::samples_per_interrupt_count_type     samplesPerInterruptCount,
    input  wire logic                      scanEnable,
    input  wire logic                      dmaModeEnable,
    input  wire logic                      bufferFillMode,
    input  wire logic                      interruptEnable,
    input  wire logic                      intFlagClear,
    input  wire adc_seq_pkg::buf_index_type readIndex,
    output adc_seq_pkg::result_type        readData,
    output logic                           intFlag,
    output logic                           interruptReq,
    output logic                           scanRestart,
    output logic                           doneFlag,
    output adc_seq_pkg::buf_index_type     writeIndex,
    output adc_seq_pkg::dma_addr_type      dmaAddress
);
    import adc_seq_pkg::*;

    if (BUFFERS != 16 || DMA_EVERY < 1 || DMA_EVERY > 256) begin : g_bad_params
        $error("Unsupported buffer count or DMA spacing");
    end

    localparam logic [7:0] DMA_LAST = 8'(DMA_EVERY - 1);

    result_type     resultBuffers_r [BUFFERS];
    buf_index_type  ptr_r;
    buf_index_type  wrIdx;
    samples_per_interrupt_count_type       sampleCnt_r;
    logic [7:0]     dmaCnt_r;
    dma_addr_type   dmaAddr_r;
    logic           intFlag_r;
    logic           scanRestart_r;
    logic           done_r;
    logic           half_r;
    conv_state_type state_r;
    result_type     readData_r;
    logic           groupEnd;

    // Count field holds conversions minus one
    assign groupEnd = convDone && (sampleCnt_r == samplesPerInterruptCount);
    assign wrIdx    = dmaModeEnable ? 4'h0 : ptr_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sampleCnt_r <= '0;
        end else if (clkEn && convDone) begin
            sampleCnt_r <= groupEnd ? '0 : samples_per_interrupt_count_type'(sampleCnt_r + 1'b1);
        end
    end

    // Conversion progress and done flag
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= CONV_IDLE;
            done_r  <= 1'b0;
        end else if (clkEn) begin
            unique case (state_r)
                CONV_IDLE: begin
                    if (convStart) begin
                        state_r <= CONV_BUSY;
                        done_r  <= 1'b0;
                    end
                end
                CONV_BUSY: begin
                    if (convDone) begin
                        state_r <= CONV_IDLE;
                        done_r  <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Result storage by sequence position only
    generate
        for (genvar i = 0; i < BUFFERS; i++) begin : g_buf
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    resultBuffers_r[i] <= `RESULT_RESET;
                end else if (clkEn && convDone && wrIdx == buf_index_type'(i)) begin
                    resultBuffers_r[i] <= convResult;
                end
            end
        end
    endgenerate

    // Buffer pointer and fill-mode halves
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_r  <= '0;
            half_r <= 1'b0;
        end else if (clkEn) begin
            if (dmaModeEnable) begin
                ptr_r <= '0;
            end else if (groupEnd) begin
                if (bufferFillMode) begin
                    half_r <= !half_r;
                    ptr_r  <= half_r ? 4'h0 : 4'h8;
                end else begin
                    ptr_r  <= '0;
                end
            end else if (convDone) begin
                ptr_r <= buf_index_type'(ptr_r + 1'b1);
            end
            if (!bufferFillMode) begin
                half_r <= 1'b0;
            end
        end
    end

    // DMA address advance
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dmaCnt_r  <= '0;
            dmaAddr_r <= `DMA_ADDR_RESET;
        end else if (clkEn && dmaModeEnable && convDone) begin
            if (dmaCnt_r == DMA_LAST) begin
                dmaCnt_r  <= '0;
                dmaAddr_r <= dma_addr_type'(dmaAddr_r + 1'b1);
            end else begin
                dmaCnt_r <= 8'(dmaCnt_r + 1'b1);
            end
        end
    end

    // Interrupt flag and scan restart; set wins over clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            intFlag_r     <= 1'b0;
            scanRestart_r <= 1'b0;
        end else if (clkEn) begin
            if (groupEnd) begin
                intFlag_r <= 1'b1;
            end else if (intFlagClear) begin
                intFlag_r <= 1'b0;
            end
            scanRestart_r <= groupEnd && scanEnable;
        end
    end

    // Read port; single buffer in DMA mode
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            readData_r <= `RESULT_RESET;
        end else if (clkEn) begin
            readData_r <= dmaModeEnable ? resultBuffers_r[0] : resultBuffers_r[readIndex];
        end
    end

    assign readData     = readData_r;
    assign intFlag      = intFlag_r;
    assign interruptReq = intFlag_r && interruptEnable;
    assign scanRestart  = scanRestart_r;
    assign doneFlag     = done_r;
    assign writeIndex   = ptr_r;
    assign dmaAddress   = dmaAddr_r;

    a_int_on_group: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && groupEnd |=> intFlag)
        else $error("Interrupt flag not set at group end");
    a_scan_restart: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && groupEnd && scanEnable |=> scanRestart)
        else $error("Scan restart missing");
    a_ptr_wraps: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && groupEnd && !dmaModeEnable && !bufferFillMode |=> writeIndex == 4'h0)
        else $error("Pointer not back at start");
    a_dma_single: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && dmaModeEnable |=> writeIndex == 4'h0)
        else $error("DMA mode used other buffer");
    a_dma_advance: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && dmaModeEnable && convDone && dmaCnt_r != DMA_LAST
        |=> $stable(dmaAddress))
        else $error("DMA address moved early");
    a_dma_step: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && dmaModeEnable && convDone && dmaCnt_r == DMA_LAST
        |=> dmaAddress == dma_addr_type'($past(dmaAddress) + 1'b1))
        else $error("DMA address did not advance");
    a_seq_fill: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && convDone && !groupEnd && !dmaModeEnable
        |=> writeIndex == buf_index_type'($past(writeIndex) + 1'b1))
        else $error("Pointer did not step");
    a_stored: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && convDone |=> resultBuffers_r[$past(wrIdx)] == $past(convResult))
        else $error("Result not stored at pointer");
    a_done_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && state_r == CONV_IDLE && convStart |=> !doneFlag)
        else $error("Done not cleared at start");
    a_done_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && state_r == CONV_BUSY && convDone |=> doneFlag)
        else $error("Done not set at completion");
    a_half_swap: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clkEn && groupEnd && !dmaModeEnable && bufferFillMode && !half_r
        |=> writeIndex == 4'h8)
        else $error("Second half not selected");
endmodule : adc_result_buffer_sequencer

// >>> result_reader.sv
/*
 Reader model: the CPU or DMA side fetching conversion results.
 Assumes readData follows readIndex one cycle later.
*/
`timescale 1ns/10ps
module result_reader (
    input  wire logic                       sys_clk,
    input  wire logic                       arst_n,
    input  wire logic                       dmaModeEnable,
    input  wire logic                       convDone,
    input  wire adc_seq_pkg::buf_index_type hostIndex,
    input  wire adc_seq_pkg::result_type    readData,
    output adc_seq_pkg::buf_index_type      readIndex,
    output adc_seq_pkg::result_type         lastDrained_r
);
    import adc_seq_pkg::*;
    logic [2:0] pipe_r;
    // Only the first buffer is read in DMA mode
    assign readIndex = dmaModeEnable ? 4'h0 : hostIndex;
    // Drains the single buffer before the next result lands
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pipe_r        <= 3'h0;
            lastDrained_r <= 12'h000;
        end else begin
            pipe_r <= {pipe_r[1:0], convDone & dmaModeEnable};
            if (pipe_r[2]) begin
                lastDrained_r <= readData;
            end
        end
    end
endmodule : result_reader

// >>> tb.sv
/*
 Testbench of the result-buffer sequencer.
 Assumes the reader model and the design package are compiled first.
*/
`timescale 1ns/10ps
module tb;
    import adc_seq_pkg::*;
    logic          sys_clk = 0, arst_n = 0, clkEn = 0, convStart = 0, convDone = 0;
    logic          scanEnable = 0, dmaModeEnable = 0, bufferFillMode = 0;
    logic          interruptEnable = 0, intFlagClear = 0, sawRestart = 0;
    logic          intFlag, interruptReq, scanRestart, doneFlag;
    result_type    convResult = 12'h000, readData, lastDrained;
    samples_per_interrupt_count_type      samplesPerInterruptCount = 5'h03;
    buf_index_type hostIndex = 4'h0, readIndex, writeIndex;
    dma_addr_type  dmaAddress;
    logic [15:0]   fillExp [4] = '{16'h0001, 16'h0008, 16'h0009, 16'h0000};
    int            errors = 0, nCompared = 0, cycles = 0;
    adc_result_buffer_sequencer i_adc_result_buffer_sequencer (.sys_clk(sys_clk),
        .arst_n(arst_n), .clkEn(clkEn), .convStart(convStart), .convDone(convDone),
        .convResult(convResult), .samplesPerInterruptCount(samplesPerInterruptCount),
        .scanEnable(scanEnable), .dmaModeEnable(dmaModeEnable),
        .bufferFillMode(bufferFillMode), .interruptEnable(interruptEnable),
        .intFlagClear(intFlagClear), .readIndex(readIndex), .readData(readData),
        .intFlag(intFlag), .interruptReq(interruptReq), .scanRestart(scanRestart),
        .doneFlag(doneFlag), .writeIndex(writeIndex), .dmaAddress(dmaAddress));
    result_reader i_result_reader (.sys_clk(sys_clk), .arst_n(arst_n),
        .dmaModeEnable(dmaModeEnable), .convDone(convDone), .hostIndex(hostIndex),
        .readData(readData), .readIndex(readIndex), .lastDrained_r(lastDrained));
    always #25 sys_clk = ~sys_clk;
    task tally_and_finish();
        if (errors == 0 && nCompared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    always @(posedge sys_clk) begin
        cycles++;
        if (scanRestart === 1'b1) sawRestart = 1;
        if (cycles > 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    task tick(int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : tick
    task check(string what, logic [15:0] exp, logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task convert(result_type v, logic probe);
        convStart = 1;
        tick(1);
        convStart = 0;
        if (probe) begin
            tick(1);
            check("doneFlag", 16'h0000, doneFlag);
        end
        convDone = 1;
        convResult = v;
        tick(1);
        convDone = 0;
        tick(3);
        if (probe) check("doneFlag", 16'h0001, doneFlag);
    endtask : convert
    initial begin
        tick(5);
        arst_n = 1;
        check("writeIndex", 16'h0000, writeIndex);
        check("dmaAddress", 16'h0000, dmaAddress);
        clkEn = 1;
        for (int p = 0; p < 2; p++) begin
            interruptEnable = (p == 0);
            scanEnable = (p == 0);
            for (int i = 0; i < 4; i++) begin
                convert(12'h100 + 12'(16 * p + i), 1'b0);
                check("intFlag", 16'(i == 3), intFlag);
                check("writeIndex", 16'((i + 1) % 4), writeIndex);
            end
            check("interruptReq", 16'(p == 0), interruptReq);
            check("scanRestart", 16'(p == 0), sawRestart);
            for (int i = 0; i < 4; i++) begin
                hostIndex = 4'(i);
                tick(2);
                check("readData", 16'h0100 + 16'(16 * p + i), readData);
            end
            intFlagClear = 1;
            tick(1);
            intFlagClear = 0;
            sawRestart = 0;
            tick(1);
            check("intFlag", 16'h0000, intFlag);
        end
        clkEn = 0;
        convert(12'hfff, 1'b0);
        check("writeIndex", 16'h0000, writeIndex);
        clkEn = 1;
        bufferFillMode = 1;
        samplesPerInterruptCount = 5'h01;
        for (int i = 0; i < 4; i++) begin
            convert(12'h0aa, i == 0);
            check("writeIndex", fillExp[i], writeIndex);
        end
        bufferFillMode = 0;
        dmaModeEnable = 1;
        samplesPerInterruptCount = 5'h1f;
        intFlagClear = 1;
        tick(1);
        intFlagClear = 0;
        for (int i = 0; i < 32; i++) begin
            convert(12'h200 + 12'(i), 1'b0);
            check("writeIndex", 16'h0000, writeIndex);
            check("lastDrained", 16'h0200 + 16'(i), lastDrained);
            check("dmaAddress", 16'(i == 31), dmaAddress);
            check("intFlag", 16'(i == 31), intFlag);
        end
        check("intFlag", 16'h0001, intFlag);
        tally_and_finish();
    end
endmodule : tb
